//--- sswl_pkg.sv
package sswl_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned LATCH_N = 6;
  localparam logic [SEL_W-1:0] SEL_LAST = 3'h0;
  localparam logic [SEL_W-1:0] SEL_FIRST = 3'h5;
  localparam logic [WORD_W-1:0] LATCH_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [SEL_W-1:0] SEL_ZERO = 3'h0;
  localparam logic [SEL_W-1:0] SEL_ONE = 3'h1;
  typedef enum logic [2:0] {
    SSWL_WAIT_FIRST = 3'b001,
    SSWL_WAIT_NEXT = 3'b010,
    SSWL_ACTIVE = 3'b100
  } sswl_init_t;
endpackage

//--- sswl_sync.sv
`timescale 1ns/1ns
module sswl_sync (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else if (ce_i) begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

//--- sswl_top.sv
`timescale 1ns/1ns
module sswl_top
  import sswl_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  input wire logic chip_power_enable_i,
  input wire logic lock_detect_i,
  input wire logic status_sel_lock_i,
  output logic multiplexed_status_out_o,
  output logic output_active_o,
  output logic [sswl_pkg::WORD_W-1:0] ctrl_word_0_o,
  output logic [sswl_pkg::WORD_W-1:0] ctrl_word_1_o,
  output logic [sswl_pkg::WORD_W-1:0] ctrl_word_2_o,
  output logic [sswl_pkg::WORD_W-1:0] ctrl_word_3_o,
  output logic [sswl_pkg::WORD_W-1:0] ctrl_word_4_o,
  output logic [sswl_pkg::WORD_W-1:0] ctrl_word_5_o,
  output logic load_pulse_o
);
  import sswl_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic clk_s, dat_s, le_s, le_n_s, pwr_s, lock_s;
  logic [4:0] raw_in, sync_out;
  // strobe synced inverted: its reset level then matches the idle-high pin, no false load after reset
  assign raw_in = {ser_clk_i, ser_data_i, !load_strobe_i, chip_power_enable_i, lock_detect_i};
  assign {clk_s, dat_s, le_n_s, pwr_s, lock_s} = sync_out;
  assign le_s = !le_n_s;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      sswl_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(raw_in[gi]),
        .sync_o(sync_out[gi])
      );
    end
  endgenerate

  // ==========================================================
  // edge detection
  logic clk_d_r, le_d_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_d_r <= 1'b0;
      le_d_r <= 1'b1;
    end else if (ce_i) begin
      clk_d_r <= clk_s;
      le_d_r <= le_s;
    end
  end
  logic clk_rise, le_rise;
  assign clk_rise = clk_s && !clk_d_r;
  assign le_rise = le_s && !le_d_r;

  // ==========================================================
  // shift register
  logic [WORD_W-1:0] shift_r;
  logic [CNT_W-1:0] cnt_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= LATCH_RST;
    end else if (ce_i && clk_rise) begin
      shift_r <= {shift_r[WORD_W-2:0], dat_s};
    end
  end

  // bit count only for diagnostics; a short word still loads what was shifted
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= CNT_ZERO;
    end else if (ce_i) begin
      if (le_rise) begin
        cnt_r <= CNT_ZERO;
      end else if (clk_rise && !le_s && cnt_r != CNT_FULL) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  function automatic logic [SEL_W-1:0] sel_of(input logic [WORD_W-1:0] w);
    sel_of = w[SEL_W-1:0];
  endfunction

  // ==========================================================
  // latches, written only on strobe rise
  logic [WORD_W-1:0] latch_r [LATCH_N];
  logic [SEL_W-1:0] sel;
  assign sel = sel_of(shift_r);
  generate
    for (gi = 0; gi < LATCH_N; gi++) begin : g_latch
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          latch_r[gi] <= LATCH_RST;
        end else if (ce_i && le_rise && sel == SEL_W'(gi)) begin
          latch_r[gi] <= shift_r;
        end
      end
    end
  endgenerate
  assign ctrl_word_0_o = latch_r[0];
  assign ctrl_word_1_o = latch_r[1];
  assign ctrl_word_2_o = latch_r[2];
  assign ctrl_word_3_o = latch_r[3];
  assign ctrl_word_4_o = latch_r[4];
  assign ctrl_word_5_o = latch_r[5];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_pulse_o <= 1'b0;
    end else if (ce_i) begin
      load_pulse_o <= le_rise && sel < SEL_W'(LATCH_N);
    end
  end

  // ==========================================================
  // power-up sequence tracker
  sswl_init_t st_r;
  logic [SEL_W-1:0] expect_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= SSWL_WAIT_FIRST;
      expect_r <= SEL_FIRST;
    end else if (ce_i && le_rise) begin
      case (st_r)
        SSWL_WAIT_FIRST: begin
          if (sel == SEL_FIRST) begin
            st_r <= SSWL_WAIT_NEXT;
            expect_r <= SEL_FIRST - SEL_ONE;
          end
        end
        SSWL_WAIT_NEXT: begin
          if (sel != expect_r) begin
            // out of order restarts the sequence
            st_r <= SSWL_WAIT_FIRST;
            expect_r <= SEL_FIRST;
          end else if (expect_r == SEL_LAST) begin
            st_r <= SSWL_ACTIVE;
          end else begin
            expect_r <= expect_r - SEL_ONE;
          end
        end
        SSWL_ACTIVE: begin
          st_r <= SSWL_ACTIVE;
        end
        default: begin
          st_r <= SSWL_WAIT_FIRST;
          expect_r <= SEL_FIRST;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs; no serial read path exists
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_active_o <= 1'b0;
      multiplexed_status_out_o <= 1'b0;
    end else if (ce_i) begin
      output_active_o <= (st_r == SSWL_ACTIVE) && pwr_s;
      multiplexed_status_out_o <= status_sel_lock_i && lock_s;
    end
  end

  // ==========================================================
  // assertions
  sequence s_le_rise;
    ce_i && le_rise;
  endsequence

  property p_shift;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (ce_i && clk_rise) |=> shift_r[0] == $past(dat_s);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit not captured");

  property p_load;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_le_rise ##0 (sel == SEL_ZERO) |=> latch_r[0] == $past(shift_r);
  endproperty
  a_load: assert property (p_load) else $error("latch 0 not loaded");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(ce_i && le_rise) |=> $stable(latch_r[1]) && $stable(latch_r[5]);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without strobe");

  property p_sel;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_le_rise ##0 (sel != SEL_FIRST) |=> $stable(latch_r[5]);
  endproperty
  a_sel: assert property (p_sel) else $error("wrong latch selected");

  property p_active;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      output_active_o |-> $past(st_r) == SSWL_ACTIVE;
  endproperty
  a_active: assert property (p_active) else $error("output active before init");

  property p_status;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      ce_i ##1 ce_i |-> multiplexed_status_out_o == ($past(status_sel_lock_i) && $past(lock_s));
  endproperty
  a_status: assert property (p_status) else $error("status pin mismatch");

  property p_cnt;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      cnt_r <= CNT_FULL;
  endproperty
  a_cnt: assert property (p_cnt) else $error("bit count past word width");
endmodule

//--- sswl_host.sv
`timescale 1ns/1ns
// ==========
// host serial port
module sswl_host (
  input wire logic ref_clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o,
  output logic chip_power_enable_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b1;
    chip_power_enable_o = 1'b1;
  end
  task automatic half();
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic set_power(input logic p);
    chip_power_enable_o = p;
  endtask
  // clock idles low outside frames, except while clock_only pulses it with the strobe high
  task automatic send_word(input logic [31:0] w);
    load_strobe_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      ser_data_o = w[i];
      half();
      ser_clk_o = 1'b1;
      half();
      half();
      ser_clk_o = 1'b0;
      half();
    end
    ser_data_o = ~ser_data_o;
    half();
    load_strobe_o = 1'b1;
    half();
  endtask
  task automatic clock_only(input int n);
    for (int i = 0; i < n; i++) begin
      ser_data_o = i[0];
      half();
      ser_clk_o = 1'b1;
      half();
      half();
      ser_clk_o = 1'b0;
      half();
    end
  endtask
endmodule

//--- sswl_top_tb.sv
`timescale 1ns/1ns
// ==========
// bench
module sswl_top_tb;
  import sswl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic lock_detect_i = 1'b0;
  logic status_sel_lock_i = 1'b0;
  logic ser_clk, ser_data, strobe, pwr, status, active, pulse;
  logic [WORD_W-1:0] cw [LATCH_N];
  int err_count = 0;
  int comparisons = 0;
  int pulses = 0;
  int cycles = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  sswl_host host (.ref_clk_i(ref_clk_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data), .load_strobe_o(strobe),
    .chip_power_enable_o(pwr));
  sswl_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .ser_clk_i(ser_clk),
    .ser_data_i(ser_data), .load_strobe_i(strobe), .chip_power_enable_i(pwr), .lock_detect_i(lock_detect_i),
    .status_sel_lock_i(status_sel_lock_i), .multiplexed_status_out_o(status), .output_active_o(active),
    .ctrl_word_0_o(cw[0]), .ctrl_word_1_o(cw[1]), .ctrl_word_2_o(cw[2]), .ctrl_word_3_o(cw[3]),
    .ctrl_word_4_o(cw[4]), .ctrl_word_5_o(cw[5]), .load_pulse_o(pulse));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    if (pulse === 1'b1)
      pulses++;
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] word(input int s);
    return {4'(s), 25'h1A5_C3E0, 3'(s)};
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic t_init();
    for (int s = 5; s >= 0; s--) begin
      check(32'(active), 32'h0000_0000);
      check(cw[s], LATCH_RST);
      host.send_word(word(s));
      check(cw[s], word(s));
    end
    check(32'(active), 32'h0000_0001);
    check(32'(pulses), 32'h0000_0006);
  endtask
  task automatic t_refuse();
    host.send_word(word(6));
    host.send_word(word(7));
    for (int s = 0; s < 6; s++)
      check(cw[s], word(s));
    check(32'(pulses), 32'h0000_0006);
  endtask
  // stray bits must fall out ahead of a full word
  task automatic t_strobe_high();
    host.clock_only(40);
    wait_n(8);
    check(cw[3], word(3));
    check(32'(pulses), 32'h0000_0006);
    host.send_word(32'hDEAD_BEE3);
    check(cw[3], 32'hDEAD_BEE3);
    check(cw[4], word(4));
  endtask
  task automatic t_status();
    lock_detect_i = 1'b1;
    status_sel_lock_i = 1'b1;
    wait_n(8);
    check(32'(status), 32'h0000_0001);
    status_sel_lock_i = 1'b0;
    wait_n(8);
    check(32'(status), 32'h0000_0000);
    status_sel_lock_i = 1'b1;
    lock_detect_i = 1'b0;
    wait_n(8);
    check(32'(status), 32'h0000_0000);
  endtask
  task automatic t_power();
    host.set_power(1'b0);
    wait_n(8);
    check(32'(active), 32'h0000_0000);
    host.set_power(1'b1);
    wait_n(8);
    check(32'(active), 32'h0000_0001);
  endtask
  initial begin
    wait_n(5);
    rst_n_i = 1'b1;
    wait_n(4);
    t_init();
    t_refuse();
    t_strobe_high();
    t_status();
    t_power();
    give_verdict();
  end
endmodule
